/* rtl/fast_pulse_counter.sv */
`timescale 1ns/1ns
module fast_pulse_counter
    import fpc_pkg::*;
#(
    parameter int NCH = NUM_CHAN,
    parameter int TICKS_PER_MS = CYCLES_PER_MS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // field pins
    input wire logic [NCH-1:0] chan_a,
    input wire logic [NCH-1:0] chan_b,
    input wire logic clear_count,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // results
    output logic [31:0] running_total,
    output logic [31:0] period_count,
    output logic goal_reached,
    output logic irq
);
    import fpc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] window_ms;
        logic [31:0] goal;
        logic [31:0] total;
        logic [31:0] win_cnt;
        logic [31:0] period;
        logic [31:0] ms_cnt;
        logic [31:0] tick_cnt;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] mask;
        logic [NCH-1:0] a_s0;
        logic [NCH-1:0] a_s1;
        logic [NCH-1:0] b_s0;
        logic [NCH-1:0] b_s1;
        logic [1:0] clr_sync;
        logic clr_prev;
        logic goal_out;
        logic irq;
        logic [31:0] rdata;
    } core_state_t;

    core_state_t q;
    core_state_t next_q;
    fpc_if evt ();

    logic [CHAN_W-1:0] chan_sel;
    logic sel_a;
    logic sel_b;
    logic clr_lvl;
    logic [NUM_EV-1:0] ev;
    logic [31:0] stepped;
    logic [31:0] ctrl_wr;

    // ----------------------------------------
    // channel select
    // ----------------------------------------
    assign chan_sel = q.ctrl[CTRL_CHAN_LSB +: CHAN_W];
    assign sel_a = q.a_s1[chan_sel];
    assign sel_b = q.b_s1[chan_sel];
    assign clr_lvl = q.clr_sync[1];

    fpc_edge u_edge (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pin_a(sel_a),
        .pin_b(sel_b),
        .hw_dir(q.ctrl[CTRL_HW_DIR]),
        .sw_dir_up(q.ctrl[CTRL_DIR_UP]),
        .evt(evt.edge_side)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_q = q;
        ev = '0;
        ctrl_wr = q.ctrl;
        next_q.clr_sync = {q.clr_sync[0], clear_count};
        // two-stage synchronisers on every channel pin
        next_q.a_s0 = chan_a;
        next_q.a_s1 = q.a_s0;
        next_q.b_s0 = chan_b;
        next_q.b_s1 = q.b_s0;
        next_q.clr_prev = clr_lvl;
        // wrap by plain 32-bit arithmetic
        stepped = evt.dir_up ? q.total + 32'h0000_0001 : q.total - 32'h0000_0001;
        next_q.goal_out = 1'b0;

        if (evt.pulse) begin
            next_q.total = stepped;
            next_q.win_cnt = q.win_cnt + 32'h0000_0001;
            if (evt.dir_up && q.total == 32'h7FFF_FFFF) begin
                ev[ST_WRAP] = 1'b1;
            end
            if (!evt.dir_up && q.total == 32'h8000_0000) begin
                ev[ST_WRAP] = 1'b1;
            end
            if (evt.dir_up && q.goal != ZERO32 && stepped == q.goal) begin
                ev[ST_GOAL] = 1'b1;
                if (q.ctrl[CTRL_GOAL_CLR]) begin
                    next_q.total = ZERO32;
                end else begin
                    next_q.goal_out = 1'b1;
                end
            end
        end

        // ----------------------------------------
        // measurement window, milliseconds
        // ----------------------------------------
        if (q.window_ms != ZERO32) begin
            if (q.tick_cnt >= 32'(TICKS_PER_MS - 1)) begin
                next_q.tick_cnt = ZERO32;
                if (q.ms_cnt >= q.window_ms - 32'h0000_0001) begin
                    next_q.ms_cnt = ZERO32;
                    next_q.period = next_q.win_cnt;
                    next_q.win_cnt = ZERO32;
                    ev[ST_WINDOW] = 1'b1;
                end else begin
                    next_q.ms_cnt = q.ms_cnt + 32'h0000_0001;
                end
            end else begin
                next_q.tick_cnt = q.tick_cnt + 32'h0000_0001;
            end
        end else begin
            next_q.tick_cnt = ZERO32;
            next_q.ms_cnt = ZERO32;
            next_q.win_cnt = ZERO32;
            next_q.period = next_q.total;
        end

        // ----------------------------------------
        // register writes
        // ----------------------------------------
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    ctrl_wr = reg_wdata;
                end
                ADDR_WINDOW: begin
                    next_q.window_ms = reg_wdata;
                    next_q.tick_cnt = ZERO32;
                    next_q.ms_cnt = ZERO32;
                    next_q.win_cnt = ZERO32;
                end
                ADDR_GOAL: begin
                    next_q.goal = reg_wdata;
                end
                ADDR_MASK: begin
                    next_q.mask = reg_wdata[NUM_EV-1:0];
                end
                default: begin
                end
            endcase
        end
        next_q.ctrl = ctrl_wr;
        next_q.ctrl[CTRL_SW_CLEAR] = 1'b0;

        // ----------------------------------------
        // clear: rising edge, held level, or software strobe
        // ----------------------------------------
        if ((clr_lvl && !q.clr_prev) || clr_lvl || ctrl_wr[CTRL_SW_CLEAR]) begin
            next_q.total = ZERO32;
            next_q.goal_out = 1'b0;
            if (q.window_ms == ZERO32) begin
                next_q.period = ZERO32;
            end
        end

        // ----------------------------------------
        // sticky status: write one clears, new event wins
        // ----------------------------------------
        if (reg_wr && reg_addr == ADDR_STATUS) begin
            next_q.status = q.status & ~reg_wdata[NUM_EV-1:0];
        end
        next_q.status = next_q.status | ev;
        next_q.irq = |(next_q.status & next_q.mask);

        // ----------------------------------------
        // register reads, data stand one cycle
        // ----------------------------------------
        next_q.rdata = ZERO32;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    next_q.rdata = q.ctrl;
                end
                ADDR_WINDOW: begin
                    next_q.rdata = q.window_ms;
                end
                ADDR_GOAL: begin
                    next_q.rdata = q.goal;
                end
                ADDR_TOTAL: begin
                    next_q.rdata = q.total;
                end
                ADDR_PERIOD: begin
                    next_q.rdata = q.period;
                end
                ADDR_STATUS: begin
                    next_q.rdata = {{(32 - NUM_EV){1'b0}}, q.status};
                end
                ADDR_MASK: begin
                    next_q.rdata = {{(32 - NUM_EV){1'b0}}, q.mask};
                end
                default: begin
                    next_q.rdata = ZERO32;
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign reg_rdata = q.rdata;
    assign running_total = q.total;
    assign period_count = q.period;
    assign goal_reached = q.goal_out;
    assign irq = q.irq;
endmodule : fast_pulse_counter

/* rtl/fpc_pkg.sv */
package fpc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_WINDOW = 4'h1;
    localparam logic [3:0] ADDR_GOAL = 4'h2;
    localparam logic [3:0] ADDR_TOTAL = 4'h3;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_MASK = 4'h6;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTRL_DIR_UP = 0;
    localparam int CTRL_HW_DIR = 1;
    localparam int CTRL_GOAL_CLR = 2;
    localparam int CTRL_SW_CLEAR = 3;
    localparam int CTRL_CHAN_LSB = 4;
    localparam int CHAN_W = 2;
    localparam int NUM_CHAN = 4;
    // ----------------------------------------
    // status fields
    // ----------------------------------------
    localparam int ST_GOAL = 0;
    localparam int ST_WINDOW = 1;
    localparam int ST_WRAP = 2;
    localparam int NUM_EV = 3;
    // ----------------------------------------
    // reset values and timing
    // ----------------------------------------
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam int MCLK_HZ = 125000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = MCLK_HZ / MS_PER_S;
    typedef logic signed [31:0] total_t;
endpackage : fpc_pkg

/* rtl/fpc_if.sv */
`timescale 1ns/1ns
interface fpc_if;
    logic pulse;
    logic dir_up;
    modport edge_side (output pulse, output dir_up);
    modport count_side (input pulse, input dir_up);
endinterface : fpc_if

/* rtl/fpc_edge.sv */
`timescale 1ns/1ns
module fpc_edge
    import fpc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // selected channel pins
    input wire logic pin_a,
    input wire logic pin_b,
    input wire logic hw_dir,
    input wire logic sw_dir_up,
    // to counter
    fpc_if.edge_side evt
);
    typedef struct packed {
        logic pa;
        logic pulse;
        logic dir_up;
    } edge_state_t;
    edge_state_t q;
    edge_state_t next_q;
    always_comb begin
        next_q = q;
        // pins arrive already synchronised
        next_q.pa = pin_a;
        next_q.pulse = pin_a & ~q.pa;
        // encoder: b low at a's rising edge counts up
        next_q.dir_up = hw_dir ? ~pin_b : sw_dir_up;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end
    assign evt.pulse = q.pulse;
    assign evt.dir_up = q.dir_up;
endmodule : fpc_edge

/* sim/fpc_sva.sv */
`timescale 1ns/1ns
module fpc_sva
    import fpc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // inputs
    input wire logic clear_count,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // results
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] running_total,
    input wire logic [31:0] period_count,
    input wire logic goal_reached
);
    logic [1:0] ctl;
    logic [31:0] goal;
    logic win0;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // shadow of the settings written by software
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl <= 2'h1;
            goal <= ZERO32;
            win0 <= 1'b1;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_CTRL) ctl <= reg_wdata[1:0];
            if (reg_addr == ADDR_GOAL) goal <= reg_wdata;
            if (reg_addr == ADDR_WINDOW) win0 <= (reg_wdata == ZERO32);
        end
    end
    sequence quiet_s;
        win0 && $stable(running_total);
    endsequence
    step_a:
    assert property ($changed(running_total) && running_total != ZERO32 |->
        (running_total - $past(running_total)) inside {32'h1, 32'hFFFF_FFFF})
        else $error("total moved by more than one");
    clear_a:
    assert property (clear_count [*4] |=> running_total == ZERO32)
        else $error("total not held at zero");
    goal_val_a:
    assert property (goal_reached |-> running_total == goal) else $error("goal pulse off value");
    goal_once_a:
    assert property (goal_reached |=> !goal_reached) else $error("goal pulse too long");
    goal_off_a:
    assert property (goal == ZERO32 |=> !goal_reached) else $error("goal pulse with goal zero");
    goal_down_a:
    assert property (ctl == 2'h0 |=> !goal_reached) else $error("goal pulse counting down");
    rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == ZERO32) else $error("read data without read");
    period_total_a:
    assert property (quiet_s [*3] |-> period_count == running_total)
        else $error("period not total");
endmodule : fpc_sva
bind fast_pulse_counter fpc_sva chk_u (.mclk(mclk), .rst(rst), .clear_count(clear_count),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .running_total(running_total), .period_count(period_count),
    .goal_reached(goal_reached));

/* sim/fpc_src.sv */
`timescale 1ns/1ns
module fpc_src (
    // clock
    input wire logic mclk,
    // field pins
    output logic [3:0] chan_a,
    output logic [3:0] chan_b
);
    initial begin
        chan_a = 4'h0;
        chan_b = 4'h0;
    end
    // each pulse two cycles high, two low
    task automatic send(input int ch, input int n, input logic b);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            chan_a[ch] <= 1'b1;
            chan_b[ch] <= b;
            repeat (2) @(posedge mclk);
            chan_a[ch] <= 1'b0;
            @(posedge mclk);
        end
    endtask : send
endmodule : fpc_src

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import fpc_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, clear_count = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, chan_a, chan_b;
    logic [31:0] reg_wdata = ZERO32, reg_rdata, running_total, period_count;
    logic goal_reached, irq;
    int bad_count = 0;
    int samples_checked = 0;
    int goal_seen = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (goal_reached === 1'b1) goal_seen++;
    fpc_src src_u (.mclk(mclk), .chan_a(chan_a), .chan_b(chan_b));
    fast_pulse_counter #(.TICKS_PER_MS(10)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
        .chan_a(chan_a), .chan_b(chan_b), .clear_count(clear_count), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .running_total(running_total), .period_count(period_count),
        .goal_reached(goal_reached), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic clr;
        @(posedge mclk);
        clear_count <= 1'b1;
        src_u.send(0, 2, 1'b0);
        clear_count <= 1'b0;
        @(posedge mclk);
        #1 chk(running_total, ZERO32);
        repeat (2) @(posedge mclk);
    endtask : clr
    task automatic t_count;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(4'h7, ZERO32);
        src_u.send(0, 5, 1'b0);
        rd(ADDR_TOTAL, 32'h5);
        wr(ADDR_CTRL, ZERO32);
        src_u.send(0, 7, 1'b0);
        rd(ADDR_TOTAL, 32'hFFFF_FFFE);
        rd(ADDR_PERIOD, 32'hFFFF_FFFE);
        clr();
        rd(ADDR_TOTAL, ZERO32);
    endtask : t_count
    task automatic t_chan;
        wr(ADDR_CTRL, 32'h21);
        src_u.send(0, 3, 1'b0);
        src_u.send(2, 4, 1'b0);
        rd(ADDR_TOTAL, 32'h4);
        wr(ADDR_CTRL, 32'h02);
        src_u.send(0, 3, 1'b0);
        src_u.send(0, 1, 1'b1);
        rd(ADDR_TOTAL, 32'h6);
    endtask : t_chan
    task automatic t_goal;
        clr();
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_GOAL, 32'h3);
        wr(ADDR_MASK, 32'h1);
        src_u.send(0, 3, 1'b0);
        rd(ADDR_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        rd(ADDR_STATUS, ZERO32);
        chk({31'h0, irq}, ZERO32);
        wr(ADDR_CTRL, 32'h5);
        clr();
        src_u.send(0, 3, 1'b0);
        rd(ADDR_TOTAL, ZERO32);
        chk(32'(goal_seen), 32'h1);
    endtask : t_goal
    task automatic t_win;
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_WINDOW, 32'h14);
        src_u.send(0, 10, 1'b0);
        for (int i = 0; i < 400 && period_count !== 32'hA; i++) @(posedge mclk);
        chk(period_count, 32'hA);
        if (period_count !== 32'hA) wrap_up();
    endtask : t_win
    task automatic wrap_up;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_count();
        t_chan();
        t_goal();
        t_win();
        wrap_up();
    end
endmodule : tb_top
